// ### bitstream_config_port_sequencing_tb_top.sv
// Bench joining the configuration host and device back to back
`timescale 1ns/100ps
`default_nettype none
module bitstream_config_port_sequencing_tb_top;
    localparam int DMIN = 50;
    localparam int NBYTES = 4;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0, h_active = 1'b0, d_active = 1'b0, jtag_mode = 1'b0;
    logic jtag_low_volt = 1'b0, in_valid = 1'b0, in_last = 1'b0;
    logic [7:0] jtag_word = 8'h00, in_byte = 8'h00;
    logic [1:0] div_sel = 2'b00;
    logic in_ready, busy, done_seen, cfg_byte_valid, load_active, load_error, user_mode;
    logic [7:0] jtag_result, cfg_byte, wire_sr;
    logic [7:0] got[$];
    logic [7:0] pat [NBYTES] = '{8'h81, 8'h5a, 8'h00, 8'hff};
    logic clk_prev = 1'b1;
    int wire_bits = 0, half_n = 0, half_run = 0, half_seen = 0;
    int error_cnt = 0, compares = 0;

    cfg_link_if link ();
    cfg_port_host #(.DMIN_CYCLES(DMIN)) cfg_port_host_inst (.mclk(mclk), .rst(rst),
        .link(link), .start(start), .active_mode(h_active), .jtag_mode(jtag_mode),
        .jtag_low_volt(jtag_low_volt), .jtag_word(jtag_word), .in_byte(in_byte),
        .in_valid(in_valid), .in_last(in_last), .in_ready(in_ready), .busy(busy),
        .done_seen(done_seen), .jtag_result(jtag_result));
    cfg_port_device #(.CFG_BYTES(NBYTES)) cfg_port_device_inst (.mclk(mclk), .rst(rst),
        .link(link), .active_mode(d_active), .div_sel(div_sel), .cfg_byte(cfg_byte),
        .cfg_byte_valid(cfg_byte_valid), .load_active(load_active),
        .load_error(load_error), .user_mode(user_mode));
    cfg_link_properties #(.DMIN_CYCLES(DMIN), .CFG_BYTES(NBYTES)) cfg_link_properties_inst (
        .mclk(mclk), .rst(rst), .creset_low(link.creset_low), .cfg_select(link.cfg_select),
        .serial_slave_select_low(link.serial_slave_select_low),
        .dev_clk_oe(link.dev_clk_oe), .dev_done_oe(link.dev_done_oe),
        .cfg_serial_data_in(link.cfg_serial_data_in),
        .cfg_serial_clock(link.cfg_serial_clock),
        .cfg_complete_flag(link.cfg_complete_flag), .tck(link.tck), .tdi(link.tdi),
        .tdo(link.tdo));

    initial begin
        forever #2.5 mclk = ~mclk;
    end

    // Byte capture and clock half-period measurement
    always @(posedge mclk) begin
        if (cfg_byte_valid === 1'b1) got.push_back(cfg_byte);
        if (link.cfg_serial_clock !== clk_prev) begin
            half_n++;
            if (half_n == 4) half_seen = half_run;
            half_run = 1;
        end else half_run++;
        clk_prev = link.cfg_serial_clock;
    end

    // First wire byte, rebuilt in arrival order
    always @(posedge link.cfg_serial_clock) begin
        if (link.serial_slave_select_low === 1'b0 && wire_bits < 8) begin
            wire_sr = {wire_sr[6:0], link.cfg_serial_data_in};
            wire_bits++;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    task automatic pulse_start;
        start = 1'b1;
        tick(1);
        start = 1'b0;
    endtask : pulse_start

    task automatic wait_idle;
        int k;
        tick(1);
        for (k = 0; k < 20000 && busy !== 1'b0; k++) tick(1);
    endtask : wait_idle

    // Stall is only legal in passive mode; active mode cannot pause
    task automatic run_load(input logic act, input logic [1:0] div, input int stall);
        int i;
        int k;
        h_active = act;
        d_active = act;
        div_sel = div;
        got.delete();
        wire_bits = 0;
        half_n = 0;
        tick(2);
        pulse_start();
        for (i = 0; i < NBYTES; i++) begin
            if (i == 2 && stall > 0) begin
                in_valid = 1'b0;
                tick(stall);
                check(16'(got.size()), 16'd2);
            end
            in_byte = pat[i];
            in_last = (i == NBYTES - 1);
            in_valid = 1'b1;
            @(posedge mclk);
            for (k = 0; k < 20000 && in_ready !== 1'b1; k++) @(posedge mclk);
            #1;
        end
        in_valid = 1'b0;
        in_last = 1'b0;
        wait_idle();
        check(16'(got.size()), NBYTES);
        for (i = 0; i < NBYTES; i++) check(got[i], pat[i]);
        check(user_mode, 1'b1);
        check(link.cfg_complete_flag, 1'b1);
        check(done_seen, 1'b1);
        check(load_error, 1'b0);
        check(half_seen, act ? (cfg_pkg::ACT_HALF_BY_ONE << div) : cfg_pkg::PAS_HALF_CYC);
        if (!act) check(wire_sr, pat[0]);
    endtask : run_load

    task automatic run_jtag(input logic lv, input logic [7:0] word);
        h_active = 1'b0;
        d_active = 1'b0;
        jtag_mode = 1'b1;
        jtag_low_volt = lv;
        jtag_word = word;
        tick(1);
        pulse_start();
        wait_idle();
        check(jtag_result, word);
        check(done_seen, 1'b1);
        jtag_mode = 1'b0;
    endtask : run_jtag

    initial begin
        tick(12);
        rst = 1'b0;
        run_load(1'b0, 2'b00, 30);
        $display("test passive load with stall done");
        for (int d = 0; d < 4; d++) run_load(1'b1, 2'(d), 0);
        $display("test active loads over all dividers done");
        run_jtag(1'b0, 8'ha5);
        run_jtag(1'b1, 8'h3c);
        $display("test jtag bypass done");
        summarize();
    end

    // Whole run is near 18000 cycles; this cuts a hang well beyond that
    initial begin
        #200us;
        error_cnt++;
        summarize();
    end
endmodule : bitstream_config_port_sequencing_tb_top
`default_nettype wire

// ### cfg_link_if.sv
// Pin-level link between configuration host and configured device
`timescale 1ns/100ps
`default_nettype none
interface cfg_link_if;
    logic creset_low;
    logic cfg_select;
    logic serial_slave_select_low;
    logic host_clk_o;
    logic host_clk_oe;
    logic dev_clk_o;
    logic dev_clk_oe;
    logic cfg_serial_data_in;
    logic dev_done_o;
    logic dev_done_oe;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic cfg_serial_clock;
    logic cfg_complete_flag;

    // Pull-ups hold both shared lines high when nobody drives
    assign cfg_serial_clock = dev_clk_oe ? dev_clk_o : (host_clk_oe ? host_clk_o : 1'b1);
    assign cfg_complete_flag = dev_done_oe ? dev_done_o : 1'b1;

    modport dev (
        input creset_low, cfg_select, serial_slave_select_low, cfg_serial_data_in,
        input cfg_serial_clock, cfg_complete_flag, tck, tms, tdi,
        output dev_clk_o, dev_clk_oe, dev_done_o, dev_done_oe, tdo
    );
    modport host (
        input cfg_serial_clock, cfg_complete_flag, tdo,
        output creset_low, cfg_select, serial_slave_select_low, cfg_serial_data_in,
        output host_clk_o, host_clk_oe, tck, tms, tdi
    );
endinterface : cfg_link_if
`default_nettype wire

// ### cfg_link_properties.sv
// Concurrent checks on the configuration link between host and device
`timescale 1ns/100ps
`default_nettype none
module cfg_link_properties #(
    parameter int DMIN_CYCLES = cfg_pkg::DMIN_CYC,
    parameter int CFG_BYTES = cfg_pkg::CFG_BYTES_DEF
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic creset_low,
    input wire logic cfg_select,
    input wire logic serial_slave_select_low,
    input wire logic dev_clk_oe,
    input wire logic dev_done_oe,
    input wire logic cfg_serial_data_in,
    input wire logic cfg_serial_clock,
    input wire logic cfg_complete_flag,
    input wire logic tck,
    input wire logic tdi,
    input wire logic tdo
);
    localparam int TRIG_MIN = cfg_pkg::TRIG_LOW_CYC;
    localparam int TAIL_MIN = 8 * CFG_BYTES + cfg_pkg::TAIL_CLKS;
    logic [15:0] trig_run_q;
    logic [15:0] rel_run_q;
    logic [15:0] rise_cnt_q;
    logic [7:0] tck_run_q;
    logic clk_prev_q;
    logic tck_prev_q;
    wire logic clk_rise = cfg_serial_clock && !clk_prev_q;
    wire logic tck_edge = tck != tck_prev_q;

    // Run-length counters saturate so long idle spans never wrap into a false pass; rise_cnt_q does not saturate
    always_ff @(posedge mclk) begin
        if (rst) begin
            trig_run_q <= 16'h0000;
            rel_run_q <= 16'h0000;
            rise_cnt_q <= 16'h0000;
            tck_run_q <= 8'h00;
            clk_prev_q <= 1'b1;
            tck_prev_q <= 1'b1;
        end else begin
            trig_run_q <= creset_low ? 16'h0000 : trig_run_q + 16'(trig_run_q != 16'hffff);
            rel_run_q <= !creset_low ? 16'h0000 : rel_run_q + 16'(rel_run_q != 16'hffff);
            rise_cnt_q <= serial_slave_select_low ? 16'h0000 : rise_cnt_q + 16'(clk_rise);
            tck_run_q <= tck_edge ? 8'h01 : tck_run_q + 8'(tck_run_q != 8'hff);
            clk_prev_q <= cfg_serial_clock;
            tck_prev_q <= tck;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_clock_idle_high: assert property (
        serial_slave_select_low && !dev_clk_oe |-> cfg_serial_clock)
        else $error("serial clock not high while idle");
    a_data_stable_rise: assert property (
        clk_rise && !serial_slave_select_low && !dev_clk_oe |-> $stable(cfg_serial_data_in))
        else $error("serial data moved at a clock rise");
    a_trig_low_width: assert property (
        $rose(creset_low) |-> trig_run_q >= TRIG_MIN)
        else $error("trigger low pulse too short");
    a_data_after_wait: assert property (
        $fell(serial_slave_select_low) |-> rel_run_q >= DMIN_CYCLES)
        else $error("serial load began too soon after trigger");
    a_jtag_after_wait: assert property (
        $fell(tck) |-> rel_run_q >= DMIN_CYCLES)
        else $error("test clock began too soon after trigger");
    a_tail_clock_count: assert property (
        $fell(dev_done_oe) |-> rise_cnt_q >= TAIL_MIN)
        else $error("done released before tail clocks");
    a_select_paired: assert property (
        !serial_slave_select_low |-> cfg_select)
        else $error("slave select low without config select");
    a_select_held_done: assert property (
        $rose(serial_slave_select_low) |-> cfg_complete_flag)
        else $error("slave select released before done");
    a_tck_half_period: assert property (
        tck_edge |-> tck_run_q >= cfg_pkg::TCK_HALF_CYC)
        else $error("test clock phase too short");
    a_tdo_on_fall: assert property (
        $changed(tdo) |-> !tck)
        else $error("test output moved while test clock high");

    c_passive_done: cover property ($fell(dev_done_oe) && !dev_clk_oe);
    c_active_done: cover property ($fell(dev_done_oe) && dev_clk_oe);
    c_jtag_shift: cover property ($fell(tck));
endmodule : cfg_link_properties
`default_nettype wire

// ### cfg_pkg.sv
// Shared constants and types for the configuration port link
`default_nettype none
package cfg_pkg;
    localparam int CLK_MHZ = 200;
    localparam int BYTE_W = 8;
    // Reconfiguration trigger low pulse, ns, and its cycle count (rounded up)
    localparam int TRIG_LOW_NS = 320;
    localparam int TRIG_LOW_CYC = (TRIG_LOW_NS * CLK_MHZ + 999) / 1000;
    // Trigger release to first data or first JTAG activity, us
    localparam int DMIN_US = 32;
    localparam int DMIN_CYC = DMIN_US * CLK_MHZ;
    // Passive serial clock ceiling, MHz; half period in cycles rounded up
    localparam int PAS_MAX_MHZ = 100;
    localparam int PAS_HALF_CYC = (CLK_MHZ + 2 * PAS_MAX_MHZ - 1) / (2 * PAS_MAX_MHZ);
    // JTAG clock ceilings, kHz, normal and 1.8 V
    localparam int TCK_MAX_KHZ = 10000;
    localparam int TCK_LV_MAX_KHZ = 3000;
    localparam int TCK_HALF_CYC = (CLK_MHZ * 1000 + 2 * TCK_MAX_KHZ - 1) / (2 * TCK_MAX_KHZ);
    localparam int TCK_LV_HALF_CYC =
        (CLK_MHZ * 1000 + 2 * TCK_LV_MAX_KHZ - 1) / (2 * TCK_LV_MAX_KHZ);
    // Clocks owed after the last bitstream bit
    localparam int TAIL_CLKS = 100;
    // Active clock half period at divide-by-one; larger settings shift it up
    // Four cycles leave the host time to reload a byte between two bits
    localparam int ACT_HALF_BY_ONE = 4;
    // Nominal active rates, MHz, for divide-by 1 and 8
    localparam int ACT_NOM_MHZ_BY_ONE = 80;
    localparam int ACT_NOM_MHZ_BY_EIGHT = 10;
    localparam int JTAG_BITS = 8;
    localparam int CFG_BYTES_DEF = 16;

    typedef enum logic [1:0] {
        clock_divide_by_one = 2'b00,
        clock_divide_by_two = 2'b01,
        clock_divide_by_four = 2'b10,
        clock_divide_by_eight = 2'b11
    } div_t;
endpackage : cfg_pkg
`default_nettype wire

// ### cfg_port_device.sv
// Configured-device end: serial bitstream capture, done flag, JTAG bypass
`timescale 1ns/100ps
`default_nettype none
module cfg_port_device #(
    parameter int CFG_BYTES = cfg_pkg::CFG_BYTES_DEF
) (
    input wire logic mclk,
    input wire logic rst,
    cfg_link_if.dev link,
    input wire logic active_mode,
    input wire logic [1:0] div_sel,
    output logic [7:0] cfg_byte,
    output logic cfg_byte_valid,
    output logic load_active,
    output logic load_error,
    output logic user_mode
);
    typedef enum logic [1:0] {
        D_IDLE = 2'b00,
        D_LOAD = 2'b01,
        D_TAIL = 2'b10,
        D_DONE = 2'b11
    } dstate_t;

    dstate_t st_q;
    logic clk_prev_q;
    logic tck_prev_q;
    logic [7:0] trig_cnt_q;
    logic [7:0] sh_q;
    logic [2:0] bit_q;
    logic [15:0] byte_cnt_q;
    logic [7:0] tail_q;
    logic act_clk_q;
    logic act_oe_q;
    logic [5:0] act_cnt_q;
    logic bypass_q;
    logic tdo_q;
    logic done_oe_q;
    logic sel_seen_q;

    wire logic sclk_rise = link.cfg_serial_clock & ~clk_prev_q;
    wire logic tck_rise = link.tck & ~tck_prev_q;
    wire logic tck_fall = ~link.tck & tck_prev_q;
    wire logic armed = trig_cnt_q >= 8'(cfg_pkg::TRIG_LOW_CYC);
    wire logic port_ok = link.cfg_select & ~link.serial_slave_select_low;
    wire logic take_bit = (st_q == D_LOAD) & sclk_rise & port_ok;
    wire logic last_byte = byte_cnt_q == 16'(CFG_BYTES - 1);
    wire logic running = (st_q == D_LOAD) | (st_q == D_TAIL);
    wire logic [5:0] act_half = 6'(cfg_pkg::ACT_HALF_BY_ONE << div_sel);
    // Select is still high while the host waits out its delay after the trigger
    wire logic sel_lost = link.serial_slave_select_low & sel_seen_q;

    assign link.dev_clk_o = act_clk_q;
    assign link.dev_clk_oe = act_oe_q;
    assign link.dev_done_o = 1'b0;
    assign link.dev_done_oe = done_oe_q;
    assign link.tdo = tdo_q;

    // Trigger pulse width and load sequencing
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q <= D_IDLE;
            trig_cnt_q <= 8'h00;
            done_oe_q <= 1'b1;
            load_error <= 1'b0;
            sel_seen_q <= 1'b0;
        end else if (!link.creset_low) begin
            // Short glitches never reach the arm level
            if (!armed) begin
                trig_cnt_q <= trig_cnt_q + 8'h01;
            end
            st_q <= D_IDLE;
            done_oe_q <= 1'b1;
            sel_seen_q <= 1'b0;
        end else begin
            trig_cnt_q <= 8'h00;
            sel_seen_q <= running & (sel_seen_q | port_ok);
            unique case (st_q)
                D_IDLE: begin
                    if (armed) begin
                        st_q <= D_LOAD;
                        load_error <= 1'b0;
                    end
                end
                D_LOAD: begin
                    if (sel_lost) begin
                        // Select lost mid-load: abort, wait for a new trigger
                        st_q <= D_IDLE;
                        load_error <= 1'b1;
                    end else if (take_bit && bit_q == 3'h7 && last_byte) begin
                        st_q <= D_TAIL;
                    end
                end
                D_TAIL: begin
                    if (sclk_rise && tail_q == 8'(cfg_pkg::TAIL_CLKS - 1)) begin
                        st_q <= D_DONE;
                        done_oe_q <= 1'b0;
                    end
                end
                D_DONE: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            clk_prev_q <= 1'b1;
            sh_q <= 8'h00;
            bit_q <= 3'h0;
            byte_cnt_q <= 16'h0000;
            tail_q <= 8'h00;
            cfg_byte <= 8'h00;
            cfg_byte_valid <= 1'b0;
        end else begin
            clk_prev_q <= link.cfg_serial_clock;
            cfg_byte_valid <= 1'b0;
            if (st_q == D_IDLE) begin
                bit_q <= 3'h0;
                byte_cnt_q <= 16'h0000;
                tail_q <= 8'h00;
            end else if (take_bit) begin
                sh_q <= {sh_q[6:0], link.cfg_serial_data_in};
                bit_q <= bit_q + 3'h1;
                if (bit_q == 3'h7) begin
                    cfg_byte <= {sh_q[6:0], link.cfg_serial_data_in};
                    cfg_byte_valid <= 1'b1;
                    byte_cnt_q <= byte_cnt_q + 16'h0001;
                end
            end else if (st_q == D_TAIL && sclk_rise) begin
                tail_q <= tail_q + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            act_clk_q <= 1'b1;
            act_oe_q <= 1'b0;
            act_cnt_q <= 6'h00;
        end else begin
            act_oe_q <= active_mode;
            // Held high until selected, so the first edge the host sees is a fall
            if (!(active_mode && running && port_ok)) begin
                act_clk_q <= 1'b1;
                act_cnt_q <= 6'h00;
            end else if (act_cnt_q == act_half - 6'h01) begin
                act_clk_q <= ~act_clk_q;
                act_cnt_q <= 6'h00;
            end else begin
                act_cnt_q <= act_cnt_q + 6'h01;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            tck_prev_q <= 1'b1;
            bypass_q <= 1'b0;
            tdo_q <= 1'b0;
        end else begin
            tck_prev_q <= link.tck;
            if (tck_rise) begin
                bypass_q <= link.tdi;
            end
            if (tck_fall) begin
                tdo_q <= bypass_q;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            load_active <= 1'b0;
            user_mode <= 1'b0;
        end else begin
            load_active <= running;
            // Another party may hold done low to align user-mode entry
            user_mode <= (st_q == D_DONE) & link.cfg_complete_flag;
        end
    end
endmodule : cfg_port_device
`default_nettype wire

// ### cfg_port_host.sv
// Configuration host end: trigger pulse, bitstream send, JTAG bypass shift
// Behaviour
// - Wait 32 us after trigger before JTAG
// - Wait 32 us after trigger before data
// - One data line, clock idles high
// - Device takes data only on clock edges
// - No valid data: stop the clock (only in passive mode; the device's active clock keeps running)
// - Resume with next data, none skipped
// - Select high, slave select low throughout
// - Slave select never released mid-load
// - At least 100 clocks after last data
// - Passive clock at most 100 MHz
// - Active clock divide 1/2/4/8 settings
// - External active clock at most 100 MHz
// - Test clock 10 MHz, 3 MHz at 1.8V
// - Device updates TDO on falling edge
// - Only this device on the bus
// - Trigger low at least 0.32 us
// - Device releases done flag when complete
`timescale 1ns/100ps
`default_nettype none
module cfg_port_host #(
    parameter int DMIN_CYCLES = cfg_pkg::DMIN_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    cfg_link_if.host link,
    input wire logic start,
    input wire logic active_mode,
    input wire logic jtag_mode,
    input wire logic jtag_low_volt,
    input wire logic [7:0] jtag_word,
    input wire logic [7:0] in_byte,
    input wire logic in_valid,
    input wire logic in_last,
    output logic in_ready,
    output logic busy,
    output logic done_seen,
    output logic [7:0] jtag_result
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_TRIG = 3'b001,
        H_WAIT = 3'b010,
        H_SEND = 3'b011,
        H_TAIL = 3'b100,
        H_DWAIT = 3'b101,
        H_JTAG = 3'b110
    } hstate_t;

    hstate_t st_q;
    logic [15:0] cnt_q;
    logic [5:0] hc_q;
    logic act_q;
    logic jt_q;
    logic lv_q;
    logic clk_q;
    logic line_prev_q;
    logic [7:0] sh_q;
    logic [3:0] left_q;
    logic have_q;
    logic last_q;
    logic sent_q;
    logic data_q;
    logic creset_q;
    logic sel_q;
    logic ssl_q;
    logic tck_q;
    logic tdi_q;
    logic [3:0] jbit_q;

    wire logic [5:0] half = (st_q == H_JTAG) ?
        (lv_q ? 6'(cfg_pkg::TCK_LV_HALF_CYC) : 6'(cfg_pkg::TCK_HALF_CYC)) :
        6'(cfg_pkg::PAS_HALF_CYC);
    wire logic half_up = hc_q == half - 6'h01;
    wire logic line_rise = link.cfg_serial_clock & ~line_prev_q;
    wire logic line_fall = ~link.cfg_serial_clock & line_prev_q;
    wire logic sending = st_q == H_SEND;
    // clock only falls with data held
    wire logic my_fall = ~act_q & clk_q & half_up & have_q & sending;
    wire logic my_rise = ~act_q & ~clk_q & half_up;
    wire logic tail_fall = ~act_q & clk_q & half_up & (st_q == H_TAIL);
    wire logic tx_fall = act_q ? (line_fall & have_q & sending) : my_fall;
    wire logic tx_rise = act_q ? line_rise : my_rise;
    wire logic bit_done = sending & tx_rise & sent_q;
    wire logic byte_done = bit_done & (left_q == 4'h1);
    wire logic take = in_valid & in_ready;
    wire logic jt_rise = ~tck_q & half_up;
    wire logic jt_fall = tck_q & half_up;

    assign link.creset_low = creset_q;
    assign link.cfg_select = sel_q;
    assign link.serial_slave_select_low = ssl_q;
    // active clock comes from the device
    assign link.host_clk_oe = ~act_q;
    assign link.host_clk_o = clk_q;
    assign link.cfg_serial_data_in = data_q;
    assign link.tck = tck_q;
    assign link.tms = 1'b0;
    assign link.tdi = tdi_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q <= H_IDLE;
            cnt_q <= 16'h0000;
            act_q <= 1'b0;
            jt_q <= 1'b0;
            lv_q <= 1'b0;
            creset_q <= 1'b1;
            sel_q <= 1'b0;
            ssl_q <= 1'b1;
            busy <= 1'b0;
            done_seen <= 1'b0;
        end else begin
            unique case (st_q)
                H_IDLE: begin
                    if (start) begin
                        st_q <= H_TRIG;
                        cnt_q <= 16'h0000;
                        act_q <= active_mode;
                        jt_q <= jtag_mode;
                        lv_q <= jtag_low_volt;
                        creset_q <= 1'b0;
                        busy <= 1'b1;
                        done_seen <= 1'b0;
                    end
                end
                H_TRIG: begin
                    cnt_q <= cnt_q + 16'h0001;
                    if (cnt_q == 16'(cfg_pkg::TRIG_LOW_CYC - 1)) begin
                        creset_q <= 1'b1;
                        cnt_q <= 16'h0000;
                        st_q <= H_WAIT;
                    end
                end
                H_WAIT: begin
                    cnt_q <= cnt_q + 16'h0001;
                    if (cnt_q == 16'(DMIN_CYCLES - 1)) begin
                        cnt_q <= 16'h0000;
                        st_q <= jt_q ? H_JTAG : H_SEND;
                        sel_q <= ~jt_q;
                        ssl_q <= jt_q;
                    end
                end
                H_SEND: begin
                    if (byte_done && last_q) begin
                        st_q <= H_TAIL;
                        cnt_q <= 16'h0000;
                    end
                end
                H_TAIL: begin
                    if (tx_rise) begin
                        cnt_q <= cnt_q + 16'h0001;
                        if (cnt_q == 16'(cfg_pkg::TAIL_CLKS - 1)) begin
                            st_q <= H_DWAIT;
                        end
                    end
                end
                H_DWAIT: begin
                    if (link.cfg_complete_flag) begin
                        st_q <= H_IDLE;
                        busy <= 1'b0;
                        done_seen <= 1'b1;
                        sel_q <= 1'b0;
                        ssl_q <= 1'b1;
                    end
                end
                H_JTAG: begin
                    if (jt_rise && jbit_q == 4'(cfg_pkg::JTAG_BITS)) begin
                        st_q <= H_IDLE;
                        busy <= 1'b0;
                        done_seen <= 1'b1;
                        ssl_q <= 1'b1;
                    end
                end
                default: begin
                    st_q <= H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            clk_q <= 1'b1;
            tck_q <= 1'b1;
            hc_q <= 6'h00;
            line_prev_q <= 1'b1;
        end else begin
            line_prev_q <= link.cfg_serial_clock;
            if (my_fall || tail_fall || my_rise) begin
                clk_q <= ~clk_q;
                hc_q <= 6'h00;
            end else if (st_q == H_JTAG && (jt_rise || jt_fall)) begin
                tck_q <= ~tck_q;
                hc_q <= 6'h00;
            end else if (!half_up) begin
                hc_q <= hc_q + 6'h01;
            end
        end
    end

    // byte handoff, nothing repeated or skipped
    always_ff @(posedge mclk) begin
        if (rst) begin
            in_ready <= 1'b0;
            have_q <= 1'b0;
            last_q <= 1'b0;
            sent_q <= 1'b0;
            sh_q <= 8'h00;
            left_q <= 4'h0;
            data_q <= 1'b1;
        end else begin
            if (take) begin
                in_ready <= 1'b0;
                have_q <= 1'b1;
                last_q <= in_last;
                sh_q <= in_byte;
                left_q <= 4'h8;
            end else begin
                in_ready <= sending & ~have_q & ~(last_q & sent_q);
                if (byte_done) begin
                    have_q <= 1'b0;
                end
            end
            if (tx_fall) begin
                data_q <= sh_q[7];
                sent_q <= 1'b1;
            end else if (bit_done) begin
                sh_q <= {sh_q[6:0], 1'b0};
                left_q <= left_q - 4'h1;
                sent_q <= 1'b0;
            end
            if (st_q == H_IDLE) begin
                last_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            jbit_q <= 4'h0;
            tdi_q <= 1'b0;
            jtag_result <= 8'h00;
        end else if (st_q != H_JTAG) begin
            jbit_q <= 4'h0;
        end else if (jt_fall) begin
            tdi_q <= (jbit_q < 4'(cfg_pkg::JTAG_BITS)) ? jtag_word[3'(jbit_q)] : 1'b0;
        end else if (jt_rise) begin
            jtag_result <= {link.tdo, jtag_result[7:1]};
            jbit_q <= jbit_q + 4'h1;
        end
    end
endmodule : cfg_port_host
`default_nettype wire
